// ===== cfg_consts.svh
`ifndef CFG_CONSTS_SVH
`define CFG_CONSTS_SVH

// ==========================================================
// Word geometry
`define CFG_WORD_W        24
`define CFG_ADDR_W        24
`define CFG_NUM_WORDS     14
`define CFG_IDX_W         4
`define CFG_LAST_IDX      4'hD

// ==========================================================
// Word addresses in configuration space
`define ADDR_BOOT_PAGE    24'h00AF90
`define ADDR_SIGNATURE    24'h00AF94
`define ADDR_OSC_SELECT   24'h00AF98
`define ADDR_OSC_CONFIG   24'h00AF9C
`define ADDR_WATCHDOG     24'h00AFA0
`define ADDR_POWER_ON     24'h00AFA4
`define ADDR_DEBUG        24'h00AFA8
`define ADDR_DEV_OPTIONS  24'h00AFAC
`define ADDR_ALT_REGSET   24'h00AFB0
`define ADDR_BOOT_SEQ     24'h00AFFC
`define ADDR_AMP1_CAL     24'h800E48
`define ADDR_AMP2_CAL     24'h800E4C
`define ADDR_ISRC_CAL     24'h800E78
`define ADDR_BOOT_MODE    24'h801000

// ==========================================================
// Shadow slot indices
`define IDX_BOOT_PAGE     4'h0
`define IDX_OSC_SELECT    4'h2
`define IDX_OSC_CONFIG    4'h3
`define IDX_WATCHDOG      4'h4
`define IDX_DEV_OPTIONS   4'h7
`define IDX_ALT_REGSET    4'h8
`define IDX_BOOT_SEQ      4'h9
`define IDX_BOOT_MODE     4'hD

// ==========================================================
// Field positions
`define F_BSLIM_HI        12
`define F_BSLIM_LO        0
`define F_BSEQ_HI         11
`define F_BSEQ_LO         0
`define F_IBSEQ_HI        23
`define F_IBSEQ_LO        12
`define F_FNOSC_HI        2
`define F_FNOSC_LO        0
`define F_TWO_SPEED_STARTUP            7
`define F_POSCMD_HI       1
`define F_POSCMD_LO       0
`define F_PIN_REMAP_ONE_WAY         5
`define F_FCKSM_HI        7
`define F_FCKSM_LO        6
`define F_MODULATOR_WRITE_LOCK         0
`define F_WDTPOST_HI      3
`define F_WDTPOST_LO      0
`define F_WATCHDOG_PRESCALE_SEL          4
`define F_WDTEN_HI        6
`define F_WDTEN_LO        5
`define F_WATCHDOG_WINDOW_DISABLE          7
`define F_WDTWIN_HI       9
`define F_WDTWIN_LO       8
`define F_ALT_VECTOR_TABLE_DISABLE         12
`define F_CTXT1_HI        2
`define F_CTXT1_LO        0
`define F_BTMODE_HI       1
`define F_BTMODE_LO       0
`define F_BOOT_SEG_DISABLE            0
`define F_BSS_HI          2
`define F_BSS_LO          1
`define F_BOOT_SEG_WRITE_ALLOW            3
`define F_GSS_HI          5
`define F_GSS_LO          4
`define F_GENERAL_SEG_WRITE_ALLOW            6
`define F_CSS_HI          11
`define F_CSS_LO          9
`define IVT_CTRL_BIT      8

// ==========================================================
// Field codes
`define SEC_NONE          2'h0
`define SEC_STANDARD      2'h1
`define SEC_ENHANCED      2'h2
`define SEC_HIGH          2'h3
`define WIN_25            2'h0
`define WIN_37_5          2'h1
`define WIN_50            2'h2
`define WIN_75            2'h3
`define IPL_NONE          3'h0
`define ERASED_WORD       24'hFFFFFF

`endif

// ===== cfg_pkg.sv
package cfg_pkg;

  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_FETCH = 4'b0010,
    ST_STORE = 4'b0100,
    ST_DONE  = 4'b1000
  } load_state_e;

  typedef enum logic [1:0] {
    BOOT_PRIVILEGED_DUAL = 2'b00,
    BOOT_PROTECTED_DUAL  = 2'b01,
    BOOT_DUAL            = 2'b10,
    BOOT_SINGLE          = 2'b11
  } boot_mode_e;

  // Flash read request toward configuration memory
  typedef struct packed {
    logic        rd;
    logic        partition;
    logic [23:0] addr;
  } flash_req_s;

  // Protection and segment settings
  typedef struct packed {
    logic [1:0]  boot_seg_protect_level;
    logic        boot_seg_present;
    logic        boot_seg_write_allow;
    logic [12:0] boot_page_limit;
    logic [1:0]  general_seg_protect_level;
    logic        general_seg_write_allow;
    logic [1:0]  config_seg_protect_level;
  } protect_s;

  // Clock and watchdog settings
  typedef struct packed {
    logic [2:0]  initial_osc_select;
    logic        osc_select_reserved;
    logic        two_speed_startup;
    logic        start_on_fast_rc_osc;
    logic        clock_switch_enable;
    logic        fail_safe_monitor_enable;
    logic        primary_osc_enable;
    logic [1:0]  primary_osc_mode;
    logic        watchdog_forced_on;
    logic        watchdog_soft_allowed;
    logic        watchdog_active_only;
    logic        watchdog_prescale_sel;
    logic [3:0]  watchdog_postscale_sel;
    logic        watchdog_window_mode;
    logic [1:0]  watchdog_window_sel;
  } clocking_s;

  // Miscellaneous device settings
  typedef struct packed {
    logic        modulator_write_lock;
    logic        pin_remap_one_way;
    logic        alt_vector_table_use;
    logic [2:0]  regset1_ipl;
    logic        regset1_valid;
    logic [1:0]  boot_partition_mode;
    logic        active_partition;
    logic        settings_valid;
  } misc_s;

endpackage

// ===== cfg_shadow_mem.sv
`timescale 1ns/1ps
`include "cfg_consts.svh"

// Shadow store for configuration words, registered read port
module cfg_shadow_mem (
  input  wire logic                    sys_clk,
  input  wire logic                    wr_en,
  input  wire logic [`CFG_IDX_W-1:0]   wr_idx,
  input  wire logic [`CFG_WORD_W-1:0]  wr_data,
  input  wire logic [`CFG_IDX_W-1:0]   rd_idx,
  output logic      [`CFG_WORD_W-1:0]  rd_data
);

  // ==========================================================
  // Storage
  logic [`CFG_WORD_W-1:0] mem [`CFG_NUM_WORDS];  // Shadow words

  // Write port
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  // Registered read port
  always_ff @(posedge sys_clk) begin
    rd_data <= mem[rd_idx];
  end

endmodule

// ===== config_word_decoder.sv
`timescale 1ns/1ps
`include "cfg_consts.svh"

// Behaviour
// - Boot protect: 11 none, 10 standard, 0x high
// - Boot segment disable bit removes boot segment
// - Boot write-allow bit 0 blocks boot writes
// - Boot page limit stored inverted, thirteen bits
// - General protect: 11 none, 10 standard, 0x high
// - General write-allow 0 blocks user writes
// - Config protect: 111/110/10x/0xx four levels
// - Lower boot sequence number picks active partition
// - Sequence valid only with exact complement
// - Alt vector table needs bit 0 and control
// - Two-speed startup begins on fast RC
// - Modulator lock bit demands key sequence
// - Initial oscillator code; 100 reserved
// - Clock switch mode: 1x off, 01, 00
// - Pin remap one-way allows single reconfiguration
// - Primary oscillator mode; 11 disables oscillator
// - Watchdog enable: forced, soft, active-only, off
// - Watchdog prescale and postscale ratios passed
// - Window mode when disable bit clear
// - Register set priority 000-110 maps IPL 1-7
// - Boot mode: single, dual, protected, privileged
// - Every reset reloads shadow words from flash
// - All reset kinds trigger fresh reload
module config_word_decoder
  import cfg_pkg::*;
(
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  output flash_req_s                   flash_req,
  input  wire logic [`CFG_WORD_W-1:0]  flash_rdata,
  input  wire logic                    flash_rvalid,
  input  wire logic                    table_rd,
  input  wire logic [`CFG_ADDR_W-1:0]  table_addr,
  output logic      [`CFG_WORD_W-1:0]  table_rdata,
  output logic                         table_rvalid,
  input  wire logic [15:0]             interrupt_control_two,
  output logic                         load_done,
  output protect_s                     protect,
  output clocking_s                    clock_cfg,
  output misc_s                        misc
);

  // ==========================================================
  // Address helpers
  function automatic logic [`CFG_ADDR_W-1:0] slot_addr(input logic [`CFG_IDX_W-1:0] i);
    case (i)
      4'h0:    slot_addr = `ADDR_BOOT_PAGE;
      4'h1:    slot_addr = `ADDR_SIGNATURE;
      4'h2:    slot_addr = `ADDR_OSC_SELECT;
      4'h3:    slot_addr = `ADDR_OSC_CONFIG;
      4'h4:    slot_addr = `ADDR_WATCHDOG;
      4'h5:    slot_addr = `ADDR_POWER_ON;
      4'h6:    slot_addr = `ADDR_DEBUG;
      4'h7:    slot_addr = `ADDR_DEV_OPTIONS;
      4'h8:    slot_addr = `ADDR_ALT_REGSET;
      4'h9:    slot_addr = `ADDR_BOOT_SEQ;
      4'hA:    slot_addr = `ADDR_AMP1_CAL;
      4'hB:    slot_addr = `ADDR_AMP2_CAL;
      4'hC:    slot_addr = `ADDR_ISRC_CAL;
      default: slot_addr = `ADDR_BOOT_MODE;
    endcase
  endfunction

  // Reverse map: address to slot, with hit flag in the top bit
  function automatic logic [`CFG_IDX_W:0] addr_slot(input logic [`CFG_ADDR_W-1:0] a);
    logic [`CFG_IDX_W:0] r;
    r = '0;
    for (int k = 0; k < `CFG_NUM_WORDS; k++) begin
      if (slot_addr(k[`CFG_IDX_W-1:0]) == a) begin
        r = {1'b1, k[`CFG_IDX_W-1:0]};
      end
    end
    return r;
  endfunction

  // Two-bit protect level decode
  function automatic logic [1:0] sec2(input logic [1:0] f);
    if (f == 2'b11) begin
      sec2 = `SEC_NONE;
    end else if (f == 2'b10) begin
      sec2 = `SEC_STANDARD;
    end else begin
      sec2 = `SEC_HIGH;
    end
  endfunction

  // Sequence word is valid when its upper half is the complement
  function automatic logic seq_ok(input logic [`CFG_WORD_W-1:0] w);
    seq_ok = (w[`F_IBSEQ_HI:`F_IBSEQ_LO] == ~w[`F_BSEQ_HI:`F_BSEQ_LO]);
  endfunction

  // ==========================================================
  // Loader state
  load_state_e             state;          // Loader phase
  logic [`CFG_IDX_W-1:0]   idx;            // Current slot
  logic                    seq_phase;      // 1 while comparing partitions
  logic [`CFG_WORD_W-1:0]  seq_a;          // Partition A sequence word
  logic                    part_sel;       // Chosen partition
  logic                    mem_wr;         // Shadow write strobe
  logic [`CFG_WORD_W-1:0]  mem_wdata;      // Shadow write data
  logic [`CFG_IDX_W-1:0]   mem_ridx;       // Shadow read index
  logic [`CFG_WORD_W-1:0]  mem_rdata;      // Shadow read data
  logic [`CFG_IDX_W:0]     hit;            // Table read decode
  logic                    rd_pend;        // Table read in flight
  logic                    rd_hit;         // Pending read maps to a slot

  // Shadow memory
  cfg_shadow_mem u_mem (
    .sys_clk (sys_clk),
    .wr_en   (mem_wr),
    .wr_idx  (idx),
    .wr_data (mem_wdata),
    .rd_idx  (mem_ridx),
    .rd_data (mem_rdata)
  );

  // ==========================================================
  // Load sequencer: any reset restarts a full reload
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state     <= ST_IDLE;
      idx       <= '0;
      seq_phase <= 1'b1;
      seq_a     <= '0;
      part_sel  <= 1'b0;
      flash_req <= '0;
      mem_wr    <= 1'b0;
      mem_wdata <= '0;
      load_done <= 1'b0;
    end else begin
      mem_wr <= 1'b0;
      case (state)
        // Start: fetch partition A sequence word
        ST_IDLE: begin
          flash_req <= '{rd: 1'b1, partition: 1'b0, addr: `ADDR_BOOT_SEQ};
          state     <= ST_FETCH;
        end
        // Wait for flash data
        ST_FETCH: begin
          flash_req.rd <= 1'b0;
          if (flash_rvalid) begin
            state <= ST_STORE;
            if (seq_phase && !flash_req.partition) begin
              seq_a     <= flash_rdata;
              flash_req <= '{rd: 1'b1, partition: 1'b1, addr: `ADDR_BOOT_SEQ};
              state     <= ST_FETCH;
            end else if (seq_phase) begin
              // Lower valid number wins; invalid side loses
              if (!seq_ok(seq_a)) begin
                part_sel <= 1'b1;
              end else if (!seq_ok(flash_rdata)) begin
                part_sel <= 1'b0;
              end else begin
                part_sel <= (flash_rdata[`F_BSEQ_HI:`F_BSEQ_LO] <
                             seq_a[`F_BSEQ_HI:`F_BSEQ_LO]);
              end
              state <= ST_DONE;
            end else begin
              mem_wr    <= 1'b1;
              mem_wdata <= flash_rdata;
            end
          end
        end
        // Advance to next slot
        ST_STORE: begin
          if (idx == `CFG_LAST_IDX) begin
            load_done <= 1'b1;
            state     <= ST_DONE;
          end else begin
            idx       <= idx + 4'h1;
            flash_req <= '{rd: 1'b1, partition: part_sel, addr: slot_addr(idx + 4'h1)};
            state     <= ST_FETCH;
          end
        end
        // Either start word load or stay settled
        ST_DONE: begin
          if (seq_phase) begin
            seq_phase <= 1'b0;
            idx       <= '0;
            flash_req <= '{rd: 1'b1, partition: part_sel, addr: slot_addr('0)};
            state     <= ST_FETCH;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Table read port, one word per request, answer next-next cycle
  always_comb begin
    hit      = addr_slot(table_addr);
    mem_ridx = hit[`CFG_IDX_W-1:0];
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_pend      <= 1'b0;
      rd_hit       <= 1'b0;
      table_rvalid <= 1'b0;
      table_rdata  <= '0;
    end else begin
      rd_pend      <= table_rd && load_done;
      rd_hit       <= hit[`CFG_IDX_W];
      table_rvalid <= rd_pend;
      // Unmapped addresses answer zero; calibration words readable for the copy step
      table_rdata  <= (rd_pend && rd_hit) ? mem_rdata : '0;
    end
  end

  // ==========================================================
  // Decoded settings, registered from shadow words
  logic [`CFG_WORD_W-1:0] w_bp;   // Boot page word
  logic [`CFG_WORD_W-1:0] w_os;   // Oscillator select word
  logic [`CFG_WORD_W-1:0] w_oc;   // Oscillator config word
  logic [`CFG_WORD_W-1:0] w_wd;   // Watchdog word
  logic [`CFG_WORD_W-1:0] w_do;   // Device options word
  logic [`CFG_WORD_W-1:0] w_ar;   // Register set word
  logic [`CFG_WORD_W-1:0] w_bm;   // Boot mode word

  // Capture the words that feed decoding as they stream in
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      w_bp <= `ERASED_WORD;
      w_os <= `ERASED_WORD;
      w_oc <= `ERASED_WORD;
      w_wd <= `ERASED_WORD;
      w_do <= `ERASED_WORD;
      w_ar <= `ERASED_WORD;
      w_bm <= `ERASED_WORD;
    end else if (mem_wr) begin
      case (idx)
        `IDX_BOOT_PAGE:   w_bp <= mem_wdata;
        `IDX_OSC_SELECT:  w_os <= mem_wdata;
        `IDX_OSC_CONFIG:  w_oc <= mem_wdata;
        `IDX_WATCHDOG:    w_wd <= mem_wdata;
        `IDX_DEV_OPTIONS: w_do <= mem_wdata;
        `IDX_ALT_REGSET:  w_ar <= mem_wdata;
        `IDX_BOOT_MODE:   w_bm <= mem_wdata;
        default:          w_bp <= w_bp;
      endcase
    end
  end

  // Protection settings; all write-allows held off until loaded
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      protect <= '0;
    end else begin
      protect.boot_seg_protect_level    <= sec2(w_do[`F_BSS_HI:`F_BSS_LO]);
      protect.boot_seg_present          <= ~w_do[`F_BOOT_SEG_DISABLE];
      protect.boot_seg_write_allow      <= load_done & w_do[`F_BOOT_SEG_WRITE_ALLOW];
      protect.boot_page_limit           <= ~w_bp[`F_BSLIM_HI:`F_BSLIM_LO];
      protect.general_seg_protect_level <= sec2(w_do[`F_GSS_HI:`F_GSS_LO]);
      protect.general_seg_write_allow   <= load_done & w_do[`F_GENERAL_SEG_WRITE_ALLOW];
      if (w_do[`F_CSS_HI:`F_CSS_LO] == 3'b111) begin
        protect.config_seg_protect_level <= `SEC_NONE;
      end else if (w_do[`F_CSS_HI:`F_CSS_LO] == 3'b110) begin
        protect.config_seg_protect_level <= `SEC_STANDARD;
      end else if (w_do[`F_CSS_HI]) begin
        protect.config_seg_protect_level <= `SEC_ENHANCED;
      end else begin
        protect.config_seg_protect_level <= `SEC_HIGH;
      end
    end
  end

  // Clock and watchdog settings
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      clock_cfg <= '0;
    end else begin
      clock_cfg.initial_osc_select  <= w_os[`F_FNOSC_HI:`F_FNOSC_LO];
      clock_cfg.osc_select_reserved <= (w_os[`F_FNOSC_HI:`F_FNOSC_LO] == 3'b100);
      clock_cfg.two_speed_startup   <= w_os[`F_TWO_SPEED_STARTUP];
      clock_cfg.start_on_fast_rc_osc <= w_os[`F_TWO_SPEED_STARTUP] |
                                        (w_os[`F_FNOSC_HI:`F_FNOSC_LO] == 3'b000);
      clock_cfg.clock_switch_enable      <= ~w_oc[`F_FCKSM_HI];
      clock_cfg.fail_safe_monitor_enable <= (w_oc[`F_FCKSM_HI:`F_FCKSM_LO] == 2'b00);
      clock_cfg.primary_osc_enable <= (w_oc[`F_POSCMD_HI:`F_POSCMD_LO] != 2'b11);
      clock_cfg.primary_osc_mode   <= w_oc[`F_POSCMD_HI:`F_POSCMD_LO];
      clock_cfg.watchdog_forced_on    <= (w_wd[`F_WDTEN_HI:`F_WDTEN_LO] == 2'b11);
      clock_cfg.watchdog_soft_allowed <= (w_wd[`F_WDTEN_HI:`F_WDTEN_LO] == 2'b10);
      clock_cfg.watchdog_active_only  <= (w_wd[`F_WDTEN_HI:`F_WDTEN_LO] == 2'b01);
      clock_cfg.watchdog_prescale_sel  <= w_wd[`F_WATCHDOG_PRESCALE_SEL];
      clock_cfg.watchdog_postscale_sel <= w_wd[`F_WDTPOST_HI:`F_WDTPOST_LO];
      clock_cfg.watchdog_window_mode   <= ~w_wd[`F_WATCHDOG_WINDOW_DISABLE];
      case (w_wd[`F_WDTWIN_HI:`F_WDTWIN_LO])
        2'b11:   clock_cfg.watchdog_window_sel <= `WIN_25;
        2'b10:   clock_cfg.watchdog_window_sel <= `WIN_37_5;
        2'b01:   clock_cfg.watchdog_window_sel <= `WIN_50;
        default: clock_cfg.watchdog_window_sel <= `WIN_75;
      endcase
    end
  end

  // Lock, remap, vector table, register sets and boot mode
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      misc <= '0;
    end else begin
      misc.modulator_write_lock <= w_do[`F_MODULATOR_WRITE_LOCK];
      misc.pin_remap_one_way    <= w_oc[`F_PIN_REMAP_ONE_WAY];
      misc.alt_vector_table_use <= ~w_bp[`F_ALT_VECTOR_TABLE_DISABLE] &
                                   interrupt_control_two[`IVT_CTRL_BIT];
      misc.regset1_valid <= (w_ar[`F_CTXT1_HI:`F_CTXT1_LO] != 3'b111);
      misc.regset1_ipl   <= (w_ar[`F_CTXT1_HI:`F_CTXT1_LO] == 3'b111) ? `IPL_NONE :
                            w_ar[`F_CTXT1_HI:`F_CTXT1_LO] + 3'h1;
      misc.boot_partition_mode <= w_bm[`F_BTMODE_HI:`F_BTMODE_LO];
      misc.active_partition    <= (w_bm[`F_BTMODE_HI:`F_BTMODE_LO] == BOOT_SINGLE) ?
                                  1'b0 : part_sel;
      misc.settings_valid      <= load_done;
    end
  end

  // ==========================================================
  // Checks
  sequence s_seq_fetch;
    flash_req.rd && flash_req.addr == `ADDR_BOOT_SEQ;
  endsequence
  property p_reload;
    @(posedge sys_clk) $fell(rst) |-> !load_done [*2] ##1 !load_done;
  endproperty
  a_reload: assert property (p_reload) else $error("loaded too early");
  property p_first_fetch;
    @(posedge sys_clk) disable iff (rst) $fell(rst) |-> ##[0:1] s_seq_fetch;
  endproperty
  a_first_fetch: assert property (p_first_fetch) else $error("no seq fetch");
  property p_boot_seg_write_allow;
    @(posedge sys_clk) disable iff (rst)
      !load_done |-> ##1 !protect.boot_seg_write_allow;
  endproperty
  a_boot_seg_write_allow: assert property (p_boot_seg_write_allow) else $error("boot write early");
  property p_general_seg_write_allow;
    @(posedge sys_clk) disable iff (rst)
      !w_do[`F_GENERAL_SEG_WRITE_ALLOW] |=> !protect.general_seg_write_allow;
  endproperty
  a_general_seg_write_allow: assert property (p_general_seg_write_allow) else $error("user write allowed");
  property p_fcksm;
    @(posedge sys_clk) disable iff (rst)
      w_oc[`F_FCKSM_HI] |=> !clock_cfg.clock_switch_enable && !clock_cfg.fail_safe_monitor_enable;
  endproperty
  a_fcksm: assert property (p_fcksm) else $error("switching not off");
  property p_wdt_forced;
    @(posedge sys_clk) disable iff (rst)
      clock_cfg.watchdog_forced_on |-> !clock_cfg.watchdog_soft_allowed;
  endproperty
  a_wdt_forced: assert property (p_wdt_forced) else $error("wdt mode clash");
  property p_ivt;
    @(posedge sys_clk) disable iff (rst)
      w_bp[`F_ALT_VECTOR_TABLE_DISABLE] |=> !misc.alt_vector_table_use;
  endproperty
  a_ivt: assert property (p_ivt) else $error("alt table on");
  property p_ipl;
    @(posedge sys_clk) disable iff (rst)
      w_ar[`F_CTXT1_HI:`F_CTXT1_LO] == 3'b000 |=> misc.regset1_ipl == 3'h1;
  endproperty
  a_ipl: assert property (p_ipl) else $error("ipl map wrong");
  property p_tread;
    @(posedge sys_clk) disable iff (rst)
      table_rd && load_done |-> ##2 table_rvalid;
  endproperty
  a_tread: assert property (p_tread) else $error("table read lost");
endmodule

// ===== tb_config_word_decoder.sv
`timescale 1ns/1ps
`include "cfg_consts.svh"
module tb_config_word_decoder import cfg_pkg::*;;
  // ==========================================================
  // Signals
  logic        sys_clk      = 1'b0;  // Bench clock
  logic        rst          = 1'b1;  // Sync reset
  logic        flash_rvalid = 1'b0;  // Flash answer strobe
  logic        table_rd     = 1'b0;  // Table read request
  logic [23:0] flash_rdata  = 24'h0;
  logic [23:0] table_addr   = 24'h0;
  logic [15:0] ict          = 16'h0; // Interrupt control word
  logic [23:0] table_rdata;
  logic        table_rvalid, load_done, got, pend, pt;
  logic [23:0] ad;
  flash_req_s  flash_req;
  protect_s    protect;
  clocking_s   clock_cfg;
  misc_s       misc;
  logic [23:0] mem [2][14];         // Flash words per partition
  logic [23:0] addrs [14] = '{`ADDR_BOOT_PAGE, `ADDR_SIGNATURE, `ADDR_OSC_SELECT,
    `ADDR_OSC_CONFIG, `ADDR_WATCHDOG, `ADDR_POWER_ON, `ADDR_DEBUG, `ADDR_DEV_OPTIONS,
    `ADDR_ALT_REGSET, `ADDR_BOOT_SEQ, `ADDR_AMP1_CAL, `ADDR_AMP2_CAL, `ADDR_ISRC_CAL,
    `ADDR_BOOT_MODE};
  integer      seed = 73131, mismatches = 0, checks_done = 0, cycles = 0, wait_n = 0;

  config_word_decoder i_dut (.sys_clk(sys_clk), .rst(rst), .flash_req(flash_req),
    .flash_rdata(flash_rdata), .flash_rvalid(flash_rvalid), .table_rd(table_rd),
    .table_addr(table_addr), .table_rdata(table_rdata), .table_rvalid(table_rvalid),
    .interrupt_control_two(ict), .load_done(load_done), .protect(protect),
    .clock_cfg(clock_cfg), .misc(misc));

  // ==========================================================
  // Clock and hang guard
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles > 20000) begin
      mismatches++;
      wrap_up();
    end
  end

  // ==========================================================
  // Flash responder, random latency, data line scrambled when idle
  always @(posedge sys_clk) begin
    got = flash_req.rd;
    ad = flash_req.addr;
    #1;
    flash_rvalid = 1'b0;
    flash_rdata = ~flash_rdata;
    if (got) begin
      pend = 1'b1;
      pt = flash_req.partition;
      wait_n = $unsigned($random(seed)) % 3;
    end
    if (pend && wait_n == 0) begin
      pend = 1'b0;
      flash_rvalid = 1'b1;
      flash_rdata = fword(pt, ad);
    end else if (pend) wait_n--;
  end

  // ==========================================================
  // Helpers
  function automatic logic [23:0] fword(logic p, logic [23:0] a);
    for (int i = 0; i < 14; i++) if (addrs[i] == a) return mem[p][i];
    return 24'h0;
  endfunction
  function automatic logic exp_part();
    logic v0 = (mem[0][9][23:12] == ~mem[0][9][11:0]);
    logic v1 = (mem[1][9][23:12] == ~mem[1][9][11:0]);
    if (mem[0][13][1:0] == 2'h3) return 1'b0;
    if (v0 && v1) return mem[1][9][11:0] < mem[0][9][11:0];
    return !v0;
  endfunction
  function automatic logic [1:0] sec2(logic [1:0] c);
    return (c == 2'h3) ? `SEC_NONE : (c == 2'h2) ? `SEC_STANDARD : `SEC_HIGH;
  endfunction
  function automatic logic [1:0] css3(logic [2:0] c);
    return (c == 3'h7) ? `SEC_NONE : (c == 3'h6) ? `SEC_STANDARD :
           c[2] ? `SEC_ENHANCED : `SEC_HIGH;
  endfunction
  task automatic check(string n, logic [23:0] s, logic [23:0] e);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  // Table read, answer stands in the cycle after the first edge following the taking edge
  task automatic tread(logic [23:0] a, logic [23:0] e, logic v);
    table_rd = 1'b1;
    table_addr = a;
    @(posedge sys_clk);
    #1 table_rd = 1'b0;
    @(posedge sys_clk);
    #1 check("rvalid", table_rvalid, v);
    if (v) check("rdata", table_rdata, e);
  endtask
  task automatic do_reset();
    rst = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 check("done_rst", load_done, 1'b0);
    rst = 1'b0;
  endtask

  // ==========================================================
  // One load with chosen boot sequence corner
  task automatic run(int k);
    logic [11:0] n;
    logic [23:0] bp, os, oc, wd, dv, ar, bm;
    logic        p;
    int          t;
    logic [1:0]  md = (k == 3) ? 2'h3 : 2'($unsigned($random(seed)) % 3);
    for (int q = 0; q < 2; q++) begin
      for (int i = 0; i < 14; i++) mem[q][i] = $random(seed);
      n = (k == 0 || k == 3) ? 12'h5A5 : $random(seed);
      mem[q][9] = ((k == 1 && q == 0) || k == 2) ? {n, n} : {~n, n};
      mem[q][13][1:0] = md;
    end
    ict = $random(seed);
    do_reset();
    if (k == 1) begin
      repeat (6) @(posedge sys_clk);
      #1 do_reset();
    end
    tread(`ADDR_WATCHDOG, 24'h0, 1'b0);
    t = 0;
    while (load_done !== 1'b1 && t < 300) begin
      @(posedge sys_clk);
      #1 t++;
    end
    repeat (2) @(posedge sys_clk);
    #1 check("done", load_done, 1'b1);
    p = exp_part();
    {bp, os, oc, wd} = {mem[p][0], mem[p][2], mem[p][3], mem[p][4]};
    {dv, ar, bm} = {mem[p][7], mem[p][8], mem[p][13]};
    check("part", misc.active_partition, p);
    check("bmode", misc.boot_partition_mode, bm[1:0]);
    check("bss", protect.boot_seg_protect_level, sec2(dv[2:1]));
    check("boot_seg_disable", protect.boot_seg_present, !dv[0]);
    check("boot_seg_write_allow", protect.boot_seg_write_allow, dv[3]);
    check("gss", protect.general_seg_protect_level, sec2(dv[5:4]));
    check("general_seg_write_allow", protect.general_seg_write_allow, dv[6]);
    check("css", protect.config_seg_protect_level, css3(dv[11:9]));
    check("osc", {clock_cfg.initial_osc_select, clock_cfg.osc_select_reserved},
          {os[2:0], os[2:0] == 3'h4});
    check("two_speed_startup", {clock_cfg.two_speed_startup, clock_cfg.start_on_fast_rc_osc},
          {os[7], os[7] || os[2:0] == 3'h0});
    check("cksm", {clock_cfg.clock_switch_enable, clock_cfg.fail_safe_monitor_enable},
          {!oc[7], oc[7:6] == 2'h0});
    check("posc", {clock_cfg.primary_osc_enable, clock_cfg.primary_osc_mode},
          {oc[1:0] != 2'h3, oc[1:0]});
    check("remap", misc.pin_remap_one_way, oc[5]);
    check("wdten", {clock_cfg.watchdog_forced_on, clock_cfg.watchdog_soft_allowed,
          clock_cfg.watchdog_active_only}, {wd[6:5] == 2'h3, wd[6:5] == 2'h2,
          wd[6:5] == 2'h1});
    check("wscale", {clock_cfg.watchdog_prescale_sel, clock_cfg.watchdog_postscale_sel},
          wd[4:0]);
    check("win", {clock_cfg.watchdog_window_mode, clock_cfg.watchdog_window_sel},
          {!wd[7], ~wd[9:8]});
    check("lock", misc.modulator_write_lock, dv[0]);
    check("ipl", {misc.regset1_valid, misc.regset1_ipl},
          {ar[2:0] != 3'h7, (ar[2:0] == 3'h7) ? 3'h0 : ar[2:0] + 3'h1});
    check("bslim", protect.boot_page_limit, {~bp[12:0]});
    check("aivt", misc.alt_vector_table_use, !bp[12] && ict[8]);
    check("valid", misc.settings_valid, 1'b1);
    for (int i = 0; i < 14; i++) if (i != 1 && i != 5) tread(addrs[i], mem[p][i], 1'b1);
    tread(24'h00AFB4, 24'h0, 1'b1);
    $display("run %0d done", k);
  endtask

  // ==========================================================
  // Verdict
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    for (int k = 0; k < 8; k++) run(k);
    wrap_up();
  end
endmodule
